// *** logic/iem_pkg.sv ***
package iem_pkg;

   // ----------------------------------------------------------------------
   // Poll bounds, error codes and byte ordinals.
   // ----------------------------------------------------------------------

   // Number of flag polls before any wait gives up.
   localparam int POLL_LIMIT = 1000;

   // Result codes returned in the upper byte of the response.
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_BUS_BUSY = 8'hc8;
   localparam logic [7:0] ERR_ACK_POLL = 8'hc9;
   localparam logic [7:0] ERR_TXDONE_TIMEOUT = 8'hca;
   localparam logic [7:0] ERR_RXFULL_TIMEOUT = 8'hcb;
   localparam logic [7:0] ERR_STOP_TIMEOUT = 8'hcc;
   localparam logic [7:0] ERR_READ_NACK = 8'hcd;

   // Direction bit placed in bit 0 of the target select byte.
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;

   // Ordinal of the byte being sent, counted from zero.
   localparam logic [1:0] IDX_SELECT = 2'h0;
   localparam logic [1:0] IDX_ADDR_HIGH = 2'h1;
   localparam logic [1:0] IDX_ADDR_LOW = 2'h2;
   localparam logic [1:0] IDX_LAST = 2'h3;

   // Reset value of the byte wide data registers.
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ----------------------------------------------------------------------
   // Carriers.
   // ----------------------------------------------------------------------

   // One transfer request from the host.
   typedef struct packed {
      logic rd;
      logic [2:0] select_code_field;
      logic [15:0] mem_addr;
      logic [7:0] data;
   } iem_req_t;

   // Result: error code high, received byte low.
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] data;
   } iem_resp_t;

   // Status flags of the bus controller.
   typedef struct packed {
      logic bus_held_flag;
      logic tx_done_flag;
      logic ack_in;
      logic rx_full_flag;
      logic stop_seen;
   } iem_flags_t;

   // Control bits and strobes toward the bus controller.
   typedef struct packed {
      logic write;
      logic bus_held;
      logic start_cond_prefix;
      logic stop_clear;
      logic master;
      logic transmit;
      logic ack_out;
      logic rx_disable;
      logic tx_load;
      logic rx_take;
   } iem_ctl_t;

endpackage

// *** logic/iem_poll_timer.sv ***
`timescale 1ns/10ps
module iem_poll_timer #(
   parameter int LIMIT = iem_pkg::POLL_LIMIT
) (
   clk,
   rst_n,
   ce,
   clear,
   step,
   last
);
   import iem_pkg::*;

   localparam int W = $clog2(LIMIT);
   localparam logic [W-1:0] LAST_V = W'(LIMIT - 1);

   input wire logic clk;
   input wire logic rst_n;
   input wire logic ce;
   input wire logic clear;
   input wire logic step;
   output logic last;

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // ----------------------------------------------------------------------
   // Poll counter.
   // ----------------------------------------------------------------------

   // One step per failed poll; cleared when the flag is seen.
   always_comb begin
      cnt_next = cnt_reg;
      if (clear) begin
         cnt_next = '0;
      end else if (step && cnt_reg != LAST_V) begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   // Register the count; a low enable freezes it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end

   // The current poll is the final one allowed.
   assign last = (cnt_reg == LAST_V);

   a_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_reg <= LAST_V)
      else $error("poll counter ran past its limit");

endmodule // iem_poll_timer

// *** logic/iem_eeprom_seq.sv ***
// Function
// - Type code fills upper four address bits.
// - Next three bits carry device select.
// - Bit zero is direction: write 0, read 1.
// - Write: start, select, two addresses, data, stop.
// - Busy bus polled 1000 times, else 200.
// - Select acknowledge polled 1000 times, else 201.
// - Transmit done polled 1000 times, code 202.
// - Transmit timeout on an address or data byte reports its ordinal instead.
// - Receive full polled 1000 times, else 203.
// - Stop detection polled 1000 times, else 204 if no earlier error.
// - Nack gives 2, 3 or 4; success 0.
// - Nack on read select gives 205.
// - Read: address in write, restart, select read.
// - Set nack-out and receive-disable, dummy read, fetch.
// - Result: code high byte, data low byte.
// - Return to slave receive after each stop.
// - Stop: clear bus held and prefix together.
`timescale 1ns/10ps
module iem_eeprom_seq #(
   // Arbitrary neutral type code; set it to the part in use.
   parameter logic [3:0] DEVICE_TYPE = 4'h5,
   parameter int POLL_MAX = iem_pkg::POLL_LIMIT
) (
   clk,
   arst_n,
   ce,
   req_valid,
   req,
   req_ready,
   resp_valid,
   resp,
   flags,
   rx_data,
   ctl,
   tx_data
);
   import iem_pkg::*;

   input wire logic clk;
   input wire logic arst_n;
   input wire logic ce;
   input wire logic req_valid;
   input wire iem_pkg::iem_req_t req;
   output logic req_ready;
   output logic resp_valid;
   output iem_pkg::iem_resp_t resp;
   input wire iem_pkg::iem_flags_t flags;
   input wire logic [7:0] rx_data;
   output iem_pkg::iem_ctl_t ctl;
   output logic [7:0] tx_data;

   typedef enum logic [3:0] {
      S_IDLE, S_BUS_CHK, S_START, S_SEND, S_WAIT_TX, S_WAIT_ACK,
      S_RX_SETUP, S_RX_DUMMY, S_RX_WAIT, S_RX_TAKE,
      S_STOP_REQ, S_STOP_WAIT, S_FINISH
   } iem_state_t;

   logic [1:0] rst_sync_reg;
   logic rst_n;
   iem_state_t state_reg, state_next;
   iem_req_t req_reg, req_next;
   logic [1:0] idx_reg, idx_next;
   logic [7:0] code_reg, code_next;
   logic [7:0] data_reg, data_next;
   logic [7:0] tx_reg, tx_next;
   iem_ctl_t ctl_reg, ctl_next;
   iem_resp_t resp_reg, resp_next;
   logic resp_valid_reg, resp_valid_next;
   logic t_clear;
   logic t_step;
   logic t_last;

   // ----------------------------------------------------------------------
   // Reset release.
   // ----------------------------------------------------------------------

   // Assert at once, release two edges later so no flop sees a runt.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------------

   // Byte to send for a given ordinal; ordinal 3 of a read is reselect.
   function automatic logic [7:0] byte_for(input iem_req_t r,
                                           input logic [1:0] idx);
      logic [7:0] b;
      b = RST_BYTE;
      case (idx)
         IDX_SELECT: b = {DEVICE_TYPE, r.select_code_field,
                          RW_WRITE};
         IDX_ADDR_HIGH: b = r.mem_addr[15:8];
         IDX_ADDR_LOW: b = r.mem_addr[7:0];
         default: begin
            if (r.rd) begin
               b = {DEVICE_TYPE, r.select_code_field, RW_READ};
            end else begin
               b = r.data;
            end
         end
      endcase
      return b;
   endfunction

   // A reselect in a read is not counted as a data ordinal.
   function automatic logic is_select(input logic rd,
                                      input logic [1:0] idx);
      return (idx == IDX_SELECT) || (rd && idx == IDX_LAST);
   endfunction

   // Ordinal code (2 to 4) of the byte being sent.
   function automatic logic [7:0] ordinal(input logic [1:0] idx);
      return {6'h00, idx} + 8'h01;
   endfunction

   // ----------------------------------------------------------------------
   // Poll bound.
   // ----------------------------------------------------------------------

   // One shared counter serves every wait; only one wait runs at a time.
   iem_poll_timer #(
      .LIMIT(POLL_MAX)
   ) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .clear(t_clear),
      .step(t_step),
      .last(t_last)
   );

   // ----------------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------------

   // Next state; every wait state polls its flag once per cycle.
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      idx_next = idx_reg;
      code_next = code_reg;
      data_next = data_reg;
      tx_next = tx_reg;
      ctl_next = ctl_reg;
      ctl_next.write = 1'b0;
      ctl_next.stop_clear = 1'b0;
      ctl_next.tx_load = 1'b0;
      ctl_next.rx_take = 1'b0;
      resp_next = resp_reg;
      resp_valid_next = 1'b0;
      t_clear = 1'b0;
      t_step = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (req_valid) begin
               req_next = req;
               idx_next = IDX_SELECT;
               code_next = ERR_NONE;
               data_next = RST_BYTE;
               t_clear = 1'b1;
               state_next = S_BUS_CHK;
            end
         end
         S_BUS_CHK: begin
            if (!flags.bus_held_flag) begin
               t_clear = 1'b1;
               ctl_next.master = 1'b1;
               ctl_next.transmit = 1'b1;
               state_next = S_START;
            end else if (t_last) begin
               code_next = ERR_BUS_BUSY;
               t_clear = 1'b1;
               state_next = S_FINISH;
            end else begin
               t_step = 1'b1;
            end
         end
         S_START: begin
            // Start and repeated start share this request.
            ctl_next.write = 1'b1;
            ctl_next.bus_held = 1'b1;
            ctl_next.start_cond_prefix = 1'b0;
            state_next = S_SEND;
         end
         S_SEND: begin
            tx_next = byte_for(req_reg, idx_reg);
            ctl_next.tx_load = 1'b1;
            t_clear = 1'b1;
            state_next = S_WAIT_TX;
         end
         S_WAIT_TX: begin
            if (flags.tx_done_flag) begin
               t_clear = 1'b1;
               state_next = S_WAIT_ACK;
            end else if (t_last) begin
               if (is_select(req_reg.rd, idx_reg)) begin
                  code_next = ERR_TXDONE_TIMEOUT;
               end else begin
                  code_next = ordinal(idx_reg);
               end
               state_next = S_STOP_REQ;
            end else begin
               t_step = 1'b1;
            end
         end
         S_WAIT_ACK: begin
            if (!flags.ack_in) begin
               t_clear = 1'b1;
               if (idx_reg == IDX_LAST) begin
                  state_next = req_reg.rd ? S_RX_SETUP : S_STOP_REQ;
               end else if (req_reg.rd && idx_reg == IDX_ADDR_LOW) begin
                  idx_next = IDX_LAST;
                  state_next = S_START;
               end else begin
                  idx_next = idx_reg + 2'h1;
                  state_next = S_SEND;
               end
            end else if (idx_reg == IDX_SELECT) begin
               // Write select acknowledge is polled again, without resending, while the part is busy writing.
               if (t_last) begin
                  code_next = ERR_ACK_POLL;
                  state_next = S_STOP_REQ;
               end else begin
                  t_step = 1'b1;
               end
            end else if (req_reg.rd && idx_reg == IDX_LAST) begin
               code_next = ERR_READ_NACK;
               state_next = S_STOP_REQ;
            end else begin
               code_next = ordinal(idx_reg);
               state_next = S_STOP_REQ;
            end
         end
         S_RX_SETUP: begin
            // Nack the only byte so the slave lets go of data.
            ctl_next.transmit = 1'b0;
            ctl_next.ack_out = 1'b1;
            ctl_next.rx_disable = 1'b1;
            state_next = S_RX_DUMMY;
         end
         S_RX_DUMMY: begin
            ctl_next.rx_take = 1'b1;
            t_clear = 1'b1;
            state_next = S_RX_WAIT;
         end
         S_RX_WAIT: begin
            if (flags.rx_full_flag) begin
               t_clear = 1'b1;
               state_next = S_RX_TAKE;
            end else if (t_last) begin
               code_next = ERR_RXFULL_TIMEOUT;
               state_next = S_STOP_REQ;
            end else begin
               t_step = 1'b1;
            end
         end
         S_RX_TAKE: begin
            data_next = rx_data;
            ctl_next.rx_take = 1'b1;
            state_next = S_STOP_REQ;
         end
         S_STOP_REQ: begin
            ctl_next.stop_clear = 1'b1;
            ctl_next.write = 1'b1;
            ctl_next.bus_held = 1'b0;
            ctl_next.start_cond_prefix = 1'b0;
            t_clear = 1'b1;
            state_next = S_STOP_WAIT;
         end
         S_STOP_WAIT: begin
            if (flags.stop_seen) begin
               t_clear = 1'b1;
               state_next = S_FINISH;
            end else if (t_last) begin
               // An earlier error is the more useful one to keep.
               if (code_reg == ERR_NONE) begin
                  code_next = ERR_STOP_TIMEOUT;
               end
               state_next = S_FINISH;
            end else begin
               t_step = 1'b1;
            end
         end
         S_FINISH: begin
            ctl_next.master = 1'b0;
            ctl_next.transmit = 1'b0;
            ctl_next.ack_out = 1'b0;
            ctl_next.rx_disable = 1'b0;
            resp_next = '{code: code_reg, data: data_reg};
            resp_valid_next = 1'b1;
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // Register the sequencer; a low enable freezes it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         req_reg <= '0;
         idx_reg <= IDX_SELECT;
         code_reg <= ERR_NONE;
         data_reg <= RST_BYTE;
         tx_reg <= RST_BYTE;
         ctl_reg <= '0;
         resp_reg <= '0;
         resp_valid_reg <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         req_reg <= req_next;
         idx_reg <= idx_next;
         code_reg <= code_next;
         data_reg <= data_next;
         tx_reg <= tx_next;
         ctl_reg <= ctl_next;
         resp_reg <= resp_next;
         resp_valid_reg <= resp_valid_next;
      end
   end

   // Outputs come straight from flops, apart from the ready handshake.
   assign req_ready = (state_reg == S_IDLE);
   assign resp_valid = resp_valid_reg;
   assign resp = resp_reg;
   assign ctl = ctl_reg;
   assign tx_data = tx_reg;

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------

   sequence seq_stop_asked;
      state_reg == S_STOP_REQ && ce;
   endsequence

   sequence seq_stop_driven;
      ctl.write && ctl.stop_clear && !ctl.bus_held && !ctl.start_cond_prefix;
   endsequence

   a_sla_type_code: assert property (@(posedge clk) disable iff (!rst_n)
      ctl.tx_load && is_select(req_reg.rd, idx_reg)
      |-> tx_data[7:4] == DEVICE_TYPE)
      else $error("select byte lacks the type code");

   a_sla_select_bits: assert property (@(posedge clk) disable iff (!rst_n)
      ctl.tx_load && is_select(req_reg.rd, idx_reg)
      |-> tx_data[3:1] == req_reg.select_code_field)
      else $error("select byte lacks the device select");

   a_sla_rw_bit: assert property (@(posedge clk) disable iff (!rst_n)
      ctl.tx_load && is_select(req_reg.rd, idx_reg)
      |-> tx_data[0] == (idx_reg == IDX_LAST))
      else $error("select byte direction bit wrong");

   a_busy_timeout: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == S_BUS_CHK && flags.bus_held_flag && t_last && ce
      ##1 ce [*2] |-> resp_valid && resp.code == ERR_BUS_BUSY)
      else $error("busy bus did not end with code 200");

   a_tx_ordinal: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == S_WAIT_TX && !flags.tx_done_flag && t_last && ce
      && !is_select(req_reg.rd, idx_reg)
      |=> code_reg == ordinal($past(idx_reg)))
      else $error("transmit timeout not reported as ordinal");

   a_nack_code: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == S_WAIT_ACK && flags.ack_in && ce && !req_reg.rd
      && idx_reg != IDX_SELECT
      |=> code_reg == ordinal($past(idx_reg)))
      else $error("missing acknowledge gave wrong code");

   a_read_nack: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == S_WAIT_ACK && flags.ack_in && ce && req_reg.rd
      && idx_reg == IDX_LAST |=> code_reg == ERR_READ_NACK)
      else $error("read select nack did not give 205");

   a_rx_setup: assert property (@(posedge clk) disable iff (!rst_n)
      ctl.rx_take |-> ctl.ack_out && ctl.rx_disable && !ctl.transmit)
      else $error("receive started without nack and disable");

   a_stop_request: assert property (@(posedge clk) disable iff (!rst_n)
      seq_stop_asked |=> seq_stop_driven)
      else $error("stop not requested by clearing both bits");

   a_slave_return: assert property (@(posedge clk) disable iff (!rst_n)
      resp_valid |-> !ctl.master && !ctl.transmit && req_ready)
      else $error("controller not back in slave receive");

endmodule // iem_eeprom_seq

// *** verif/iem_ctrl_model.sv ***
`timescale 1ns/10ps
module iem_ctrl_model (
   clk,
   arst_n,
   ctl,
   busy,
   slow,
   nack_at,
   stall_at,
   stall_rx,
   stall_stop,
   rd_byte,
   flags,
   rx_data
);
   import iem_pkg::*;
   input wire logic clk;
   input wire logic arst_n;
   input wire iem_pkg::iem_ctl_t ctl;
   input wire logic busy;
   input wire logic slow;
   input wire logic [2:0] nack_at;
   input wire logic [2:0] stall_at;
   input wire logic stall_rx;
   input wire logic stall_stop;
   input wire logic [7:0] rd_byte;
   output iem_pkg::iem_flags_t flags;
   output logic [7:0] rx_data;

   logic [2:0] num_reg;
   logic [1:0] tx_wait_reg;
   logic held_reg;
   logic rxf_reg;
   logic stop_reg;

   // ----------------------------------------------------------------------
   // Controller and memory state.
   // ----------------------------------------------------------------------
   // A start clears stop and receive state, so a stalled earlier transfer
   // cannot leak a stale flag into the next one.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         num_reg <= 3'h0;
         tx_wait_reg <= 2'h0;
         held_reg <= 1'b0;
         rxf_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         if (ctl.tx_load) begin
            num_reg <= num_reg + 3'h1;
            tx_wait_reg <= slow ? 2'h3 : 2'h0;
         end else if (tx_wait_reg != 2'h0) begin
            tx_wait_reg <= tx_wait_reg - 2'h1;
         end
         if (ctl.write) begin
            held_reg <= ctl.bus_held;
         end
         if (ctl.write && ctl.stop_clear) begin
            num_reg <= 3'h0;
            stop_reg <= 1'b1;
         end else if (ctl.write && ctl.bus_held) begin
            stop_reg <= 1'b0;
            rxf_reg <= 1'b0;
         end else if (ctl.rx_take) begin
            rxf_reg <= ~rxf_reg;
         end
      end
   end

   // Flags; the data line shows the inverse byte while nothing is received.
   always_comb begin
      flags.bus_held_flag = held_reg | busy;
      flags.tx_done_flag = (tx_wait_reg == 2'h0) && !ctl.tx_load &&
                           (num_reg != stall_at);
      flags.ack_in = (num_reg == nack_at);
      flags.rx_full_flag = rxf_reg & ~stall_rx;
      flags.stop_seen = stop_reg & ~stall_stop;
      rx_data = flags.rx_full_flag ? rd_byte : ~rd_byte;
   end
endmodule // iem_ctrl_model

// *** verif/iem_eeprom_seq_tb.sv ***
`timescale 1ns/10ps
module iem_eeprom_seq_tb;
   import iem_pkg::*;

   // Arbitrary type code, unrelated to any real part.
   localparam logic [3:0] DEV_TYPE = 4'h6;
   // A short poll bound keeps every timeout case to a few cycles.
   localparam int POLLS = 8;

   typedef struct packed {
      logic rd;
      logic [2:0] sel;
      logic [15:0] addr;
      logic [7:0] data;
      logic [2:0] nack_at;
      logic [2:0] stall_at;
      logic stall_rx;
      logic stall_stop;
      logic busy;
      logic slow;
      logic [7:0] code;
   } iem_row_t;

   // rd sel addr data nack stall rxstall stopstall busy slow code
   iem_row_t rows [16] = '{
      '{1'b0,3'h0,16'h0000,8'h5a,3'h0,3'h0,1'b0,1'b0,1'b0,1'b0,ERR_NONE},
      '{1'b0,3'h7,16'hffff,8'ha5,3'h0,3'h0,1'b0,1'b0,1'b0,1'b1,ERR_NONE},
      '{1'b1,3'h5,16'h8001,8'hc3,3'h0,3'h0,1'b0,1'b0,1'b0,1'b1,ERR_NONE},
      '{1'b0,3'h2,16'h1234,8'h11,3'h2,3'h0,1'b0,1'b0,1'b0,1'b0,8'h02},
      '{1'b0,3'h3,16'h1234,8'h11,3'h3,3'h0,1'b0,1'b0,1'b0,1'b0,8'h03},
      '{1'b0,3'h4,16'h1234,8'h11,3'h4,3'h0,1'b0,1'b0,1'b0,1'b0,8'h04},
      '{1'b1,3'h1,16'h4321,8'h22,3'h4,3'h0,1'b0,1'b0,1'b0,1'b0,ERR_READ_NACK},
      '{1'b0,3'h6,16'h4321,8'h22,3'h1,3'h0,1'b0,1'b0,1'b0,1'b0,ERR_ACK_POLL},
      '{1'b0,3'h0,16'h0001,8'h33,3'h0,3'h0,1'b0,1'b0,1'b1,1'b0,ERR_BUS_BUSY},
      '{1'b0,3'h0,16'h0002,8'h33,3'h0,3'h1,1'b0,1'b0,1'b0,1'b0,ERR_TXDONE_TIMEOUT},
      '{1'b0,3'h0,16'h0003,8'h33,3'h0,3'h3,1'b0,1'b0,1'b0,1'b0,8'h03},
      '{1'b1,3'h2,16'h0004,8'h44,3'h0,3'h2,1'b0,1'b0,1'b0,1'b0,8'h02},
      '{1'b1,3'h2,16'h0005,8'h44,3'h0,3'h4,1'b0,1'b0,1'b0,1'b0,ERR_TXDONE_TIMEOUT},
      '{1'b1,3'h3,16'h0006,8'h55,3'h0,3'h0,1'b1,1'b0,1'b0,1'b0,ERR_RXFULL_TIMEOUT},
      '{1'b0,3'h3,16'h0007,8'h55,3'h0,3'h0,1'b0,1'b1,1'b0,1'b0,ERR_STOP_TIMEOUT},
      '{1'b0,3'h1,16'h0008,8'h66,3'h2,3'h0,1'b0,1'b1,1'b0,1'b0,8'h02}
   };

   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic req_valid = 1'b0;
   iem_req_t req = '0;
   iem_row_t cur = '0;
   iem_row_t row_busy;
   logic req_ready;
   logic resp_valid;
   iem_resp_t resp;
   iem_flags_t flags;
   logic [7:0] rx_data;
   iem_ctl_t ctl;
   logic [7:0] tx_data;
   logic [7:0] log_q [$];
   int miscompares = 0;
   int n_checks = 0;

   always #5 clk = ~clk;

   iem_eeprom_seq #(.DEVICE_TYPE(DEV_TYPE), .POLL_MAX(POLLS))
      iem_eeprom_seq_inst (.clk(clk), .arst_n(arst_n), .ce(ce),
      .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp(resp), .flags(flags),
      .rx_data(rx_data), .ctl(ctl), .tx_data(tx_data));

   iem_ctrl_model iem_ctrl_model_inst (.clk(clk), .arst_n(arst_n),
      .ctl(ctl), .busy(cur.busy), .slow(cur.slow), .nack_at(cur.nack_at),
      .stall_at(cur.stall_at), .stall_rx(cur.stall_rx),
      .stall_stop(cur.stall_stop), .rd_byte(cur.data), .flags(flags),
      .rx_data(rx_data));

   // ----------------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Outputs that reset must force, whatever was in flight.
   task automatic reset_vals();
      check(16'(ctl), 16'h0000);
      check(resp, 16'h0000);
      check({tx_data, 6'h00, req_ready, resp_valid}, 16'h0002);
   endtask

   task automatic start_req(input iem_row_t r);
      cur = r;
      log_q.delete();
      req = '{r.rd, r.sel, r.addr, r.data};
      req_valid = 1'b1;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
   endtask

   // Bounded wait for the answer, then result, mode and byte checks.
   task automatic finish_req(input iem_row_t r);
      logic [7:0] s;
      logic [7:0] exp_q [$];
      int n;
      s = {DEV_TYPE, r.sel, RW_WRITE};
      exp_q = '{s, r.addr[15:8], r.addr[7:0], r.rd ? (s | 8'h01) : r.data};
      n = 0;
      while (resp_valid !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({15'h0000, resp_valid}, 16'h0001);
      check(resp, {r.code, (r.rd && r.code == ERR_NONE) ? r.data : 8'h00});
      // Mode bits and the receive set-up must all be back to slave receive.
      check({ctl.master, ctl.transmit, ctl.ack_out, ctl.rx_disable},
            16'h0000);
      if (r.code == ERR_NONE) begin
         check(16'(log_q.size()), 16'h0004);
         foreach (exp_q[i]) check(log_q[i], exp_q[i]);
      end
   endtask

   // Log each loaded byte; stop and receive strobes need their mode bits.
   always @(posedge clk) begin
      if (ctl.tx_load === 1'b1 && ce) log_q.push_back(tx_data);
      if (ctl.stop_clear === 1'b1)
         check({ctl.write, ctl.bus_held, ctl.start_cond_prefix}, 16'h0004);
      if (ctl.rx_take === 1'b1)
         check({ctl.ack_out, ctl.rx_disable, ctl.transmit}, 16'h0006);
   end

   // ----------------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      #1;
      reset_vals();
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      foreach (rows[i]) begin
         start_req(rows[i]);
         finish_req(rows[i]);
      end
      // Busy for fewer polls than the bound, with the clock enable low for
      // longer than the bound: frozen cycles must not count as polls.
      row_busy = rows[0];
      row_busy.busy = 1'b1;
      start_req(row_busy);
      ce = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      ce = 1'b1;
      repeat (POLLS - 2) @(posedge clk);
      #1;
      cur.busy = 1'b0;
      finish_req(rows[0]);
      // Reset in mid-transfer, then a clean read afterwards.
      start_req(rows[1]);
      repeat (6) @(posedge clk);
      #1;
      arst_n = 1'b0;
      #1;
      reset_vals();
      @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      start_req(rows[2]);
      finish_req(rows[2]);
      print_verdict();
   end

   // Watchdog well beyond the expected run of several hundred cycles.
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end
endmodule // iem_eeprom_seq_tb
